// File: core/acquisition_scan_sequencer.sv
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module acquisition_scan_sequencer
  import scan_seq_pkg::*;
#(
  parameter int QUEUE_DEPTH = 16,
  parameter int CODE_W      = 14
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 external_trigger_input,
  input  wire logic                 event_count_input,
  input  wire logic                 sync_i,
  output logic                      sync_o,
  output logic                      sync_oe,
  output logic [2:0]                conv_channel,
  output scan_seq_pkg::range_t      conv_range,
  output logic                      conv_diff,
  output logic                      conv_start,
  input  wire logic                 conv_done,
  input  wire logic [CODE_W-1:0]    conv_data,
  output logic                      scan_busy
);
  import scan_seq_pkg::*;

  localparam int IDX_W = $clog2(QUEUE_DEPTH);

  typedef struct packed {
    seq_state_t                         st;
    logic                               ext_pace;
    logic                               gated;
    logic                               trig_en;
    logic                               trig_fall;
    logic                               sync_in;
    logic                               diff;
    logic                               queue_en;
    logic [31:0]                        pacer_period;
    logic [31:0]                        pace_cnt;
    logic                               sync_out;
    logic [31:0]                        total;
    logic [31:0]                        samples;
    logic [31:0]                        events;
    logic [IDX_W-1:0]                   qlast;
    logic [IDX_W-1:0]                   qidx;
    logic [QUEUE_DEPTH-1:0][ENTRY_W-1:0] queue;
    logic [CODE_W-1:0]                  code;
    logic                               overrun;
    logic [2:0]                         chan;
    range_t                             rng;
    logic                               start;
    logic                               wr_pend;
    logic [7:0]                         wr_addr;
    logic [31:0]                        rdata;
  } regs_t;

  regs_t q;
  regs_t d;

  logic trig_rise;
  logic trig_fall_edge;
  logic event_rise;
  logic sync_rise;

  edge_detect u_trig (
    .clock (clock),
    .rst   (rst),
    .level (external_trigger_input),
    .rise  (trig_rise),
    .fall  (trig_fall_edge)
  );

  edge_detect u_event (
    .clock (clock),
    .rst   (rst),
    .level (event_count_input),
    .rise  (event_rise),
    .fall  ()
  );

  edge_detect u_sync (
    .clock (clock),
    .rst   (rst),
    .level (sync_i),
    .rise  (sync_rise),
    .fall  ()
  );

  // read multiplexer
  function automatic logic [31:0] read_reg(input regs_t r, input logic [7:0] a);
    logic [31:0]            v;
    logic signed [15:0]     offs;
    v    = 32'h0000_0000;
    offs = 16'($signed({2'b00, r.code}) - $signed({2'b00, MIDSCALE_CODE}));
    if (a == OFF_CTRL) begin
      v[CTRL_EXT_PACE]  = r.ext_pace;
      v[CTRL_GATED]     = r.gated;
      v[CTRL_TRIG_EN]   = r.trig_en;
      v[CTRL_TRIG_FALL] = r.trig_fall;
      v[CTRL_SYNC_IN]   = r.sync_in;
      v[CTRL_DIFF]      = r.diff;
      v[CTRL_QUEUE_EN]  = r.queue_en;
    end else if (a == OFF_STATUS) begin
      v[STAT_BUSY]                          = (r.st != ST_IDLE);
      v[STAT_ARMED]                         = (r.st == ST_ARM);
      v[STAT_OVERRUN]                       = r.overrun;
      v[STAT_IDX_LSB +: IDX_W]              = r.qidx;
    end else if (a == OFF_PACER) begin
      v = r.pacer_period;
    end else if (a == OFF_TOTAL) begin
      v = r.total;
    end else if (a == OFF_COUNT) begin
      v = r.samples;
    end else if (a == OFF_QLAST) begin
      v[IDX_W-1:0] = r.qlast;
    end else if (a == OFF_EVENTS) begin
      v = r.events;
    end else if (a == OFF_RESULT) begin
      v[CODE_W-1:0] = r.code;
      v[31:16]      = offs;
    end else if (a >= OFF_QUEUE && a <= OFF_QUEUE_END) begin
      v[ENTRY_W-1:0] = r.queue[a[IDX_W+1:2]];
    end
    return v;
  endfunction : read_reg

  logic                addr_take;
  logic                trig_hit;
  logic                pace;
  logic                pacer_tick;
  logic [31:0]         period_m1;
  logic [ENTRY_W-1:0]  entry;
  logic [IDX_W-1:0]    use_idx;
  logic [31:0]         samples_inc;
  logic                first_ext_drop;
  logic                ctrl_wr;
  logic                start_req;
  logic                stop_req;
  logic                clear_req;

  always_comb begin
    d       = q;
    d.start = 1'b0;

    addr_take = hsel & htrans[1] & hready;

    // control strobes of a control write in its data phase
    ctrl_wr   = q.wr_pend & (q.wr_addr == OFF_CTRL);
    start_req = ctrl_wr & hwdata[CTRL_START] & (q.total != 32'h0000_0000);
    stop_req  = ctrl_wr & hwdata[CTRL_STOP];
    clear_req = ctrl_wr & hwdata[CTRL_EVT_CLEAR];

    // internal pacer, free running so a second unit has a clock while sync is an output and the period is 2 or more
    if (q.pacer_period == 32'h0000_0000) begin
      period_m1 = 32'h0000_0000;
    end else begin
      period_m1 = q.pacer_period - 32'h0000_0001;
    end
    pacer_tick = (q.pace_cnt >= period_m1);
    d.pace_cnt = pacer_tick ? 32'h0000_0000 : q.pace_cnt + 32'h0000_0001;
    d.sync_out = (q.pace_cnt < {1'b0, q.pacer_period[31:1]});

    // pacing source: external pulses only when sync is an input
    pace = q.ext_pace ? (q.sync_in & sync_rise) : pacer_tick;

    // selected trigger edge
    trig_hit = q.trig_fall ? trig_fall_edge : trig_rise;

    // drop first pulse only for continuous external pacing
    first_ext_drop = q.ext_pace & ~q.gated;

    // event counter; clear then count so an edge in the clear cycle survives
    d.events = q.events;
    if (clear_req) begin
      d.events = 32'h0000_0000;
    end
    if (event_rise) begin
      d.events = d.events + 32'h0000_0001;
    end

    // address phase
    d.wr_pend = addr_take & hwrite;
    d.wr_addr = haddr[7:0];
    if (addr_take && !hwrite) begin
      d.rdata = read_reg(q, haddr[7:0]);
    end

    // data phase writes
    if (q.wr_pend) begin
      if (q.wr_addr == OFF_CTRL) begin
        d.ext_pace  = hwdata[CTRL_EXT_PACE];
        d.gated     = hwdata[CTRL_GATED];
        d.trig_en   = hwdata[CTRL_TRIG_EN];
        d.trig_fall = hwdata[CTRL_TRIG_FALL];
        d.sync_in   = hwdata[CTRL_SYNC_IN];
        d.diff      = hwdata[CTRL_DIFF];
        d.queue_en  = hwdata[CTRL_QUEUE_EN];
      end else if (q.wr_addr == OFF_STATUS) begin
        if (hwdata[STAT_OVERRUN]) begin
          d.overrun = 1'b0;
        end
      end else if (q.wr_addr == OFF_PACER) begin
        d.pacer_period = hwdata;
        d.pace_cnt     = 32'h0000_0000;
      end else if (q.wr_addr == OFF_TOTAL) begin
        d.total = hwdata;
      end else if (q.wr_addr == OFF_QLAST) begin
        d.qlast = hwdata[IDX_W-1:0];
      end else if (q.wr_addr >= OFF_QUEUE && q.wr_addr <= OFF_QUEUE_END) begin
        d.queue[q.wr_addr[IDX_W+1:2]] = hwdata[ENTRY_W-1:0];
      end
    end

    // current entry
    if (q.queue_en) begin
      use_idx = q.qidx;
    end else begin
      use_idx = '0;
    end
    entry       = q.queue[use_idx];
    samples_inc = q.samples + 32'h0000_0001;

    // a pace pulse while converting is lost and flagged
    if (pace && (q.st == ST_LOAD || q.st == ST_WAIT_DONE)) begin
      d.overrun = 1'b1;
    end

    case (q.st)
      ST_IDLE: begin
        if (start_req) begin
          d.samples = 32'h0000_0000;
          d.qidx    = '0;
          if (hwdata[CTRL_TRIG_EN]) begin
            d.st = ST_ARM;
          end else if (hwdata[CTRL_EXT_PACE] && !hwdata[CTRL_GATED]) begin
            d.st = ST_DISCARD;
          end else begin
            d.st = ST_WAIT_PACE;
          end
        end
      end
      ST_ARM: begin
        if (trig_hit) begin
          d.st = first_ext_drop ? ST_DISCARD : ST_WAIT_PACE;
        end
      end
      ST_DISCARD: begin
        if (pace) begin
          d.st = ST_WAIT_PACE;
        end
      end
      ST_WAIT_PACE: begin
        if (pace) begin
          d.chan = q.diff ? {1'b0, entry[ENTRY_CHAN_LSB +: 2]} : entry[ENTRY_CHAN_LSB +: 3];
          d.rng  = range_t'(entry[ENTRY_RANGE_LSB +: 3]);
          d.st   = ST_LOAD;
        end
      end
      ST_LOAD: begin
        d.start = 1'b1;
        d.st    = ST_WAIT_DONE;
      end
      ST_WAIT_DONE: begin
        if (conv_done && !q.start) begin
          d.code    = conv_data;
          d.samples = samples_inc;
          if (!q.queue_en || q.qidx == q.qlast) begin
            d.qidx = '0;
          end else begin
            d.qidx = q.qidx + 1'b1;
          end
          if (samples_inc == q.total) begin
            d.st = ST_IDLE;
          end else begin
            d.st = ST_WAIT_PACE;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // software stop wins over any progress
    if (stop_req) begin
      d.st    = ST_IDLE;
      d.start = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q              <= '0;
      q.st           <= ST_IDLE;
      q.pacer_period <= PACER_RESET;
      q.total        <= TOTAL_RESET;
      q.rng          <= range_bipolar_ten_volt;
      q.qlast        <= '0;
    end else begin
      q <= d;
    end
  end

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = q.rdata;
  assign sync_o       = q.sync_out;
  assign sync_oe      = ~q.sync_in;
  assign conv_channel = q.chan;
  assign conv_range   = q.rng;
  assign conv_diff    = q.diff;
  assign conv_start   = q.start;
  assign scan_busy    = (q.st != ST_IDLE);

endmodule : acquisition_scan_sequencer

// File: core/scan_seq_pkg.sv
package scan_seq_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_STATUS     = 8'h04;
  localparam logic [7:0] OFF_PACER      = 8'h08;
  localparam logic [7:0] OFF_TOTAL      = 8'h0C;
  localparam logic [7:0] OFF_COUNT      = 8'h10;
  localparam logic [7:0] OFF_QLAST      = 8'h14;
  localparam logic [7:0] OFF_EVENTS     = 8'h18;
  localparam logic [7:0] OFF_RESULT     = 8'h1C;
  localparam logic [7:0] OFF_QUEUE      = 8'h40;
  localparam logic [7:0] OFF_QUEUE_END  = 8'h7C;

  // control fields
  localparam int CTRL_START      = 0;
  localparam int CTRL_STOP       = 1;
  localparam int CTRL_EXT_PACE   = 2;
  localparam int CTRL_GATED      = 3;
  localparam int CTRL_TRIG_EN    = 4;
  localparam int CTRL_TRIG_FALL  = 5;
  localparam int CTRL_SYNC_IN    = 6;
  localparam int CTRL_DIFF       = 7;
  localparam int CTRL_QUEUE_EN   = 8;
  localparam int CTRL_EVT_CLEAR  = 9;

  // status fields
  localparam int STAT_BUSY       = 0;
  localparam int STAT_ARMED      = 1;
  localparam int STAT_OVERRUN    = 2;
  localparam int STAT_IDX_LSB    = 8;

  // queue entry fields
  localparam int ENTRY_W         = 6;
  localparam int ENTRY_CHAN_LSB  = 0;
  localparam int ENTRY_RANGE_LSB = 3;

  // timing
  localparam int CLOCK_HZ        = 25_000_000;
  localparam int EXT_MAX_HZ      = 48_000;
  localparam int EVENT_MAX_HZ    = 1_000_000;
  localparam int PACER_MIN_CYCLES = (CLOCK_HZ + EXT_MAX_HZ - 1) / EXT_MAX_HZ;
  localparam int EVENT_MIN_CYCLES = CLOCK_HZ / EVENT_MAX_HZ;

  // reset values and the midscale code
  localparam logic [31:0] PACER_RESET  = 32'(PACER_MIN_CYCLES);
  localparam logic [31:0] TOTAL_RESET  = 32'h0000_0000;
  localparam logic [13:0] MIDSCALE_CODE = 14'h2000;

  typedef enum logic [2:0] {
    range_bipolar_twenty_volt,
    range_bipolar_ten_volt,
    range_bipolar_five_volt,
    range_bipolar_four_volt,
    range_bipolar_two_half_volt,
    range_bipolar_two_volt,
    range_bipolar_one_quarter_volt,
    range_bipolar_one_volt
  } range_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM,
    ST_DISCARD,
    ST_WAIT_PACE,
    ST_LOAD,
    ST_WAIT_DONE
  } seq_state_t;

endpackage : scan_seq_pkg

// File: core/edge_detect.sv
`timescale 1ns/1ps
module edge_detect (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic seen;
    logic prev;
  } edge_state_t;

  edge_state_t q;
  edge_state_t d;

  // no edge reported before the first sample
  always_comb begin
    d      = q;
    d.seen = 1'b1;
    d.prev = level;
  end

  assign rise = q.seen & level & ~q.prev;
  assign fall = q.seen & ~level & q.prev;

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : edge_detect

// File: dv/scan_seq_monitor.sv
`timescale 1ns/1ps
module scan_seq_monitor (
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           sync_o,
  input  wire logic           sync_oe,
  input  wire logic [2:0]     conv_channel,
  input  scan_seq_pkg::range_t conv_range,
  input  wire logic           conv_diff,
  input  wire logic           conv_start,
  input  wire logic           scan_busy
);
  import scan_seq_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_issue;
    conv_start;
  endsequence
  sequence s_quiet;
    !conv_start [*3];
  endsequence

  property p_spacing;
    s_issue |=> s_quiet;
  endproperty
  a_spacing: assert property (p_spacing) else $error("conversion starts too close");
  property p_start_busy;
    conv_start |-> scan_busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start outside a scan");
  property p_applied;
    conv_start |-> $stable({conv_channel, conv_range});
  endproperty
  a_applied: assert property (p_applied) else $error("channel not set before start");
  property p_cfg_hold;
    !$stable({conv_channel, conv_range}) |-> scan_busy;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("channel moved while idle");
  property p_diff_chan;
    conv_start && conv_diff |-> !conv_channel[2];
  endproperty
  a_diff_chan: assert property (p_diff_chan) else $error("diff channel above three");
  property p_first_gap;
    $rose(scan_busy) |-> !conv_start ##1 !conv_start;
  endproperty
  a_first_gap: assert property (p_first_gap) else $error("start without load step");
  property p_sync_dir;
    disable iff (1'b0) rst |=> sync_oe;
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync not output after reset");
  property p_sync_run;
    sync_oe |-> ##[1:600] (sync_o != $past(sync_o));
  endproperty
  a_sync_run: assert property (p_sync_run) else $error("pacer output stuck");
endmodule : scan_seq_monitor

bind acquisition_scan_sequencer scan_seq_monitor scan_seq_monitor_i (
  .clock(clock), .rst(rst), .sync_o(sync_o), .sync_oe(sync_oe), .conv_channel(conv_channel),
  .conv_range(conv_range), .conv_diff(conv_diff), .conv_start(conv_start), .scan_busy(scan_busy));

// File: dv/conv_front_model.sv
`timescale 1ns/1ps
module conv_front_model (
  input  wire logic           clock,
  input  wire logic           conv_start,
  input  wire logic [2:0]     conv_channel,
  input  scan_seq_pkg::range_t conv_range,
  input  wire logic [3:0]     lat,
  output logic                conv_done,
  output logic [13:0]         conv_data
);
  import scan_seq_pkg::*;
  logic [4:0] wait_q = 5'h00;
  logic [5:0] cr_q   = 6'h00;
  initial conv_done = 1'b0;
  initial conv_data = 14'h0000;
  always @(posedge clock) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data; // no held code outside done
    if (conv_start) begin
      wait_q <= {1'b0, lat} + 5'h01;
      cr_q   <= {conv_channel, conv_range};
    end else if (wait_q != 5'h00) begin
      wait_q <= wait_q - 5'h01;
      if (wait_q == 5'h01) begin
        conv_done <= 1'b1;
        conv_data <= MIDSCALE_CODE + 14'(cr_q);
      end
    end
  end
endmodule : conv_front_model

// File: dv/acquisition_scan_sequencer_test.sv
`timescale 1ns/1ps
module acquisition_scan_sequencer_test;
  import scan_seq_pkg::*;
  logic        clock = 0, rst = 1, hwrite = 0, trig = 0, evt = 0, ext = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  logic        hreadyout, hresp, sync_o, sync_oe, conv_diff, conv_start, conv_done, scan_busy;
  logic [2:0]  conv_channel;
  range_t      conv_range;
  logic [13:0] conv_data;
  logic [3:0]  lat = 0;
  logic [5:0]  qv [16];
  logic [5:0]  got [$];
  int          errors = 0, total_checks = 0, cyc = 0;
  wire         sync_pin = sync_oe ? sync_o : ext;

  acquisition_scan_sequencer acquisition_scan_sequencer_i (
    .clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .external_trigger_input(trig), .event_count_input(evt), .sync_i(sync_pin),
    .sync_o(sync_o), .sync_oe(sync_oe), .conv_channel(conv_channel), .conv_range(conv_range),
    .conv_diff(conv_diff), .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
    .scan_busy(scan_busy));
  conv_front_model conv_front_model_i (
    .clock(clock), .conv_start(conv_start), .conv_channel(conv_channel), .conv_range(conv_range),
    .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

  initial forever #20 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (conv_start === 1'b1) got.push_back({conv_channel, conv_range});
    if (cyc == 60000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= 32'(a);
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus

  task automatic wait_idle();
    repeat (2) @(posedge clock);
    while (scan_busy !== 1'b0) @(posedge clock);
  endtask : wait_idle

  task automatic pulse();
    ext <= 1'b1;
    repeat (200) @(posedge clock);
    ext <= 1'b0;
    repeat (400) @(posedge clock);
  endtask : pulse

  task automatic check_scan(input int n, input int ql, input bit q_on, input bit d);
    logic [5:0] v;
    logic [5:0] e;
    check(32'(got.size()), 32'(n));
    foreach (got[i]) begin
      v = qv[q_on ? i % (ql + 1) : 0];
      e = {v[2] & !d, v[1:0], v[5:3]};
      check(32'(got[i]), 32'(e));
    end
    bus(OFF_RESULT, 0, 0);
    check(rv, {16'(e), 2'b00, MIDSCALE_CODE + 14'(e)});
    bus(OFF_COUNT, 0, 0);
    check(rv, 32'(n));
    got.delete();
  endtask : check_scan

  initial begin
    int n;
    void'($urandom(32'h4375ecd9));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(OFF_PACER, 0, 0);
    check(rv, PACER_RESET);
    check(32'(sync_oe), 1);
    check(32'(conv_range), 32'(range_bipolar_ten_volt));
    check(32'(hresp), 0);
    bus(8'h30, 0, 0);
    check(rv, 0);
    $display("test reset done");
    bus(OFF_PACER, 1, 20);
    for (int d = 0; d < 2; d++) begin
      lat <= 4'($urandom);
      bus(OFF_QLAST, 1, d ? 15 : 3);
      bus(OFF_TOTAL, 1, d ? 18 : 10);
      for (int i = 0; i < 16; i++) begin
        qv[i] = 6'($urandom);
        bus(OFF_QUEUE + 8'(4 * i), 1, 32'(qv[i]));
      end
      bus(OFF_CTRL, 1, 32'h0000_0101 | 32'(d) << 3 | 32'(d) << 7);
      @(posedge clock);
      check(32'(conv_diff), 32'(d));
      repeat (24) @(posedge clock);
      check(32'(got.size() != 0), 1);
      wait_idle();
      check_scan(d ? 18 : 10, d ? 15 : 3, 1, d[0]);
      $display("test queue %0d done", d);
    end
    for (int g = 0; g < 2; g++) begin
      bus(OFF_TOTAL, 1, 3);
      bus(OFF_CTRL, 1, 32'h0000_0045 | 32'(g) << 3);
      @(posedge clock);
      check(32'(sync_oe), 0);
      repeat (50) @(posedge clock);
      repeat (3) pulse();
      check(32'(got.size()), 32'(2 + g));
      if (g == 0) pulse();
      wait_idle();
      check_scan(3, 0, 0, 0);
      $display("test external %0d done", g);
    end
    for (int f = 0; f < 2; f++) begin
      trig <= (f == 0);
      bus(OFF_TOTAL, 1, 1);
      bus(OFF_CTRL, 1, 32'h0000_0011 | 32'(f) << 5);
      repeat (60) @(posedge clock);
      bus(OFF_STATUS, 0, 0);
      check(32'(rv[1:0]), 3);
      trig <= (f != 0);
      repeat (60) @(posedge clock);
      check(32'(got.size()), 0);
      trig <= (f == 0);
      wait_idle();
      check_scan(1, 0, 0, 0);
      $display("test trigger %0d done", f);
    end
    bus(OFF_PACER, 1, 2);
    bus(OFF_TOTAL, 1, 100);
    bus(OFF_CTRL, 1, 32'h0000_0001);
    repeat (100) @(posedge clock);
    bus(OFF_CTRL, 1, 32'h0000_0002);
    @(posedge clock);
    check(32'(scan_busy), 0);
    n = got.size();
    repeat (40) @(posedge clock);
    check(32'(got.size()), 32'(n));
    bus(OFF_STATUS, 0, 0);
    check(32'(rv[2]), 1);
    bus(OFF_STATUS, 1, 4);
    bus(OFF_STATUS, 0, 0);
    check(32'(rv[2]), 0);
    got.delete();
    $display("test stop done");
    bus(OFF_CTRL, 1, 32'h0000_0200);
    n = 1 + $urandom % 40;
    repeat (n) begin
      evt <= 1'b1;
      repeat (13) @(posedge clock);
      evt <= 1'b0;
      repeat (12) @(posedge clock);
    end
    repeat (3) @(posedge clock);
    bus(OFF_EVENTS, 0, 0);
    check(rv, 32'(n));
    bus(OFF_CTRL, 1, 32'h0000_0200);
    bus(OFF_EVENTS, 0, 0);
    check(rv, 0);
    $display("test events done");
    stop_test();
  end
endmodule : acquisition_scan_sequencer_test
